// file: hw/qpc_top.sv
// quadrature position control: axi4-lite control registers, quadrature decode and position counter
// assumes encoder pins and idle/home levels are asynchronous; one 10 MHz clock
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`include "qpc_regs.svh"
module qpc_top #(
	parameter int POS_W = 32
) (
	input  wire logic            i_clk,
	input  wire logic            i_rst_n,
	input  wire logic            i_phase_a_input,
	input  wire logic            i_phase_b_input,
	input  wire logic            i_index,
	input  wire logic            i_home,
	input  wire logic            i_idle,
	input  wire logic            s_axi_awvalid,
	output logic                 s_axi_awready,
	input  wire logic [7:0]      s_axi_awaddr,
	input  wire logic            s_axi_wvalid,
	output logic                 s_axi_wready,
	input  wire qpc_pkg::qpc_word_t s_axi_wdata,
	input  wire logic [3:0]      s_axi_wstrb,
	output logic                 s_axi_bvalid,
	input  wire logic            s_axi_bready,
	output logic [1:0]           s_axi_bresp,
	input  wire logic            s_axi_arvalid,
	output logic                 s_axi_arready,
	input  wire logic [7:0]      s_axi_araddr,
	output logic                 s_axi_rvalid,
	input  wire logic            s_axi_rready,
	output qpc_pkg::qpc_word_t   s_axi_rdata,
	output logic [1:0]           s_axi_rresp,
	output logic [POS_W-1:0]     o_position,
	output logic                 o_index_event
);
	import qpc_pkg::*;

	// elaboration check: the counter must fit a bus word
	if (POS_W < 2 || POS_W > 32) begin : g_bad_width
		$error("qpc_top: POS_W must be 2..32");
	end

	// two-flop synchronisers, one per asynchronous pin
	localparam int NSYNC = 5;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	assign pin_raw = {i_idle, i_home, i_index, i_phase_b_input, i_phase_a_input};
	for (genvar g = 0; g < NSYNC; g++) begin : g_sync
		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				sync1_reg[g] <= 1'b0;
				sync2_reg[g] <= 1'b0;
			end else begin
				sync1_reg[g] <= pin_raw[g];
				sync2_reg[g] <= sync1_reg[g];
			end
		end
	end
	logic pa, pb, idx, home, idle;
	assign {idle, home, idx, pb, pa} = sync2_reg;

	// control and compare registers
	qpc_word_t ctrl_reg;
	logic [POS_W-1:0] init_reg, gec_reg, lec_reg;
	logic             en, sidl, imv_a, imv_b;
	qpc_mode_e        mode;
	assign en    = ctrl_reg[`QPC_BIT_EN];
	assign sidl  = ctrl_reg[`QPC_BIT_SIDL];
	assign imv_a = ctrl_reg[`QPC_BIT_IMV_A];
	assign imv_b = ctrl_reg[`QPC_BIT_IMV_B];
	assign mode  = qpc_mode_e'(ctrl_reg[`QPC_MODE_HI:`QPC_MODE_LO]); // RULE4

	// stop-in-idle freezes counting, registers stay reachable
	logic run;
	assign run = en && !(sidl && idle); // RULE1 RULE3

	// index event: index high with both phases at their match levels
	logic idx_hit;
	assign idx_hit = run && idx && (pa == imv_a) && (pb == imv_b); // RULE12 RULE13 RULE14
	assign o_index_event = idx_hit;

	// quadrature decode from previous phase pair
	logic [1:0] ab_prev_reg;
	logic       step_up, step_dn;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ab_prev_reg <= 2'b00;
		end else begin
			ab_prev_reg <= {pa, pb};
		end
	end
	always_comb begin
		step_up = 1'b0;
		step_dn = 1'b0;
		if ({pa, pb} != ab_prev_reg) begin
			// gray sequence 00-01-11-10 of {a, b} counts up
			step_up = (ab_prev_reg[1] ^ pb);
			step_dn = !(ab_prev_reg[1] ^ pb);
			if (ab_prev_reg == {~pa, ~pb}) begin // double step: illegal, ignore
				step_up = 1'b0;
				step_dn = 1'b0;
			end
		end
	end

	// home tracking: counts index events since the last home event
	logic       armed_reg;   // for mode 010
	logic [1:0] home_cnt_reg;
	logic       home_seen_reg;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			home_seen_reg <= 1'b0;
			home_cnt_reg  <= 2'd0;
		end else if (run && home) begin
			home_seen_reg <= 1'b1;
			home_cnt_reg  <= 2'd0;
		end else if (idx_hit && home_seen_reg) begin
			home_cnt_reg  <= (home_cnt_reg == 2'd2) ? 2'd2 : home_cnt_reg + 2'd1;
			if ((mode == QPC_MODE_HOME1) || (home_cnt_reg == 2'd1)) begin
				home_seen_reg <= 1'b0; // one load per home event
			end
		end
	end

	// mode 010 loads once, re-armed by writing the control register
	logic ctrl_wr;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			armed_reg <= 1'b1;
		end else if (ctrl_wr) begin
			armed_reg <= 1'b1;
		end else if (idx_hit && mode == QPC_MODE_NEXT) begin
			armed_reg <= 1'b0;
		end
	end

	// position counter
	logic [POS_W-1:0] pos_reg, pos_next;
	logic             pos_wr;
	qpc_word_t        wdata_hold;
	always_comb begin
		pos_next = pos_reg;
		if (step_up) begin
			pos_next = pos_reg + 1'b1;
		end else if (step_dn) begin
			pos_next = pos_reg - 1'b1;
		end
		unique case (mode)
			QPC_MODE_NONE: ; // RULE5
			QPC_MODE_EVERY: if (idx_hit) pos_next = '0; // RULE6
			QPC_MODE_NEXT: if (idx_hit && armed_reg) pos_next = init_reg; // RULE7
			QPC_MODE_HOME1: if (idx_hit && home_seen_reg) pos_next = init_reg; // RULE8
			QPC_MODE_HOME2: if (idx_hit && home_seen_reg && home_cnt_reg == 2'd1) pos_next = init_reg; // RULE9
			QPC_MODE_GEC: if (pos_reg == gec_reg) pos_next = '0; // RULE10
			QPC_MODE_MODULO: begin // RULE11
				if (step_up && pos_reg == gec_reg) pos_next = lec_reg;
				else if (step_dn && pos_reg == lec_reg) pos_next = gec_reg;
			end
			QPC_MODE_RSVD: ; // reserved code behaves as no index effect
		endcase
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pos_reg <= '0;
		end else if (pos_wr) begin
			pos_reg <= wdata_hold[POS_W-1:0];
		end else if (run) begin
			pos_reg <= pos_next; // RULE1
		end
	end
	assign o_position = pos_reg;

	// axi4-lite write: address and data taken in either order
	logic       aw_have_reg, w_have_reg;
	logic [7:0] awaddr_hold;
	logic [3:0] wstrb_hold;
	logic       do_write;
	assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
	assign do_write      = aw_have_reg && w_have_reg && !s_axi_bvalid;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			awaddr_hold <= 8'h00;
			wdata_hold  <= '0;
			wstrb_hold  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				awaddr_hold <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wdata_hold <= s_axi_wdata;
				wstrb_hold <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
			end
		end
	end

	// byte-lane merge for a register write
	function automatic qpc_word_t merge(qpc_word_t old, qpc_word_t nw, logic [3:0] be);
		qpc_word_t r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction : merge

	logic addr_ok_w;
	assign addr_ok_w = (awaddr_hold[1:0] == 2'b00) && (awaddr_hold <= `QPC_OFS_LEC);
	assign ctrl_wr   = do_write && awaddr_hold == `QPC_OFS_CTRL;
	assign pos_wr    = do_write && awaddr_hold == `QPC_OFS_POS && wstrb_hold == 4'hF;
	qpc_word_t init_w, gec_w, lec_w;
	assign init_w = qpc_word_t'(init_reg);
	assign gec_w  = qpc_word_t'(gec_reg);
	assign lec_w  = qpc_word_t'(lec_reg);

	// register updates; unimplemented control bits masked away
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_reg <= `QPC_CTRL_RST;
			init_reg <= '0;
			gec_reg  <= '1;
			lec_reg  <= '0;
		end else if (do_write) begin
			unique case (awaddr_hold)
				`QPC_OFS_CTRL: ctrl_reg <= merge(ctrl_reg, wdata_hold, wstrb_hold) & `QPC_CTRL_MASK; // RULE2
				`QPC_OFS_INIT: init_reg <= POS_W'(merge(init_w, wdata_hold, wstrb_hold));
				`QPC_OFS_GEC:  gec_reg  <= POS_W'(merge(gec_w, wdata_hold, wstrb_hold));
				`QPC_OFS_LEC:  lec_reg  <= POS_W'(merge(lec_w, wdata_hold, wstrb_hold));
				default: ;
			endcase
		end
	end

	// write response one cycle after both halves are held
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `QPC_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= addr_ok_w ? `QPC_RESP_OKAY : `QPC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read channel: data registered one cycle after the address
	assign s_axi_arready = !s_axi_rvalid;
	qpc_word_t rd_mux;
	logic      rd_ok;
	always_comb begin
		rd_ok  = 1'b1;
		rd_mux = '0;
		unique case (s_axi_araddr)
			`QPC_OFS_CTRL: rd_mux = ctrl_reg & `QPC_CTRL_MASK; // RULE2
			`QPC_OFS_POS:  rd_mux = qpc_word_t'(pos_reg);
			`QPC_OFS_INIT: rd_mux = init_w;
			`QPC_OFS_GEC:  rd_mux = gec_w;
			`QPC_OFS_LEC:  rd_mux = lec_w;
			`QPC_OFS_STAT: rd_mux = {26'h000_0000, home_seen_reg, armed_reg, run, pb, pa, idx};
			default:       rd_ok  = 1'b0;
		endcase
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `QPC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_ok ? `QPC_RESP_OKAY : `QPC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// checks
	chk_disabled_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!en && !pos_wr |=> pos_reg == $past(pos_reg)) else $error("counter moved while disabled"); // RULE1
	chk_idle_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		sidl && idle && !pos_wr |=> $stable(pos_reg)) else $error("counter moved in idle"); // RULE3
	chk_ctrl_unimpl: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(ctrl_reg & ~`QPC_CTRL_MASK) == 32'h0000_0000) else $error("unimplemented bit set"); // RULE2
	chk_mode_every: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		idx_hit && mode == QPC_MODE_EVERY && !pos_wr |=> pos_reg == '0) else $error("index did not clear"); // RULE6
	chk_mode_next: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		idx_hit && mode == QPC_MODE_NEXT && armed_reg && !pos_wr |=> pos_reg == $past(init_reg))
		else $error("index did not load"); // RULE7
	chk_mode_home1: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		idx_hit && mode == QPC_MODE_HOME1 && home_seen_reg && !pos_wr |=> pos_reg == $past(init_reg))
		else $error("first index after home did not load"); // RULE8
	chk_mode_gec: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		run && mode == QPC_MODE_GEC && pos_reg == gec_reg && !pos_wr |=> pos_reg == '0)
		else $error("compare match did not clear"); // RULE10
	chk_index_match: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_index_event |-> idx && pa == imv_a && pb == imv_b) else $error("index without phase match"); // RULE14
	cov_index_load: cover property (@(posedge i_clk) disable iff (!i_rst_n) idx_hit && mode == QPC_MODE_NEXT);
	cov_home2: cover property (@(posedge i_clk) disable iff (!i_rst_n) idx_hit && mode == QPC_MODE_HOME2);
	cov_modulo_wrap: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		run && mode == QPC_MODE_MODULO && step_up && pos_reg == gec_reg);
endmodule : qpc_top

// file: pkg/qpc_pkg.sv
// types for the quadrature position control block
// assumes qpc_regs.svh supplies the numeric constants
package qpc_pkg;
	typedef enum logic [2:0] {
		QPC_MODE_NONE   = 3'h0,
		QPC_MODE_EVERY  = 3'h1,
		QPC_MODE_NEXT   = 3'h2,
		QPC_MODE_HOME1  = 3'h3,
		QPC_MODE_HOME2  = 3'h4,
		QPC_MODE_GEC    = 3'h5,
		QPC_MODE_MODULO = 3'h6,
		QPC_MODE_RSVD   = 3'h7
	} qpc_mode_e;
	typedef logic [31:0] qpc_word_t;
endpackage : qpc_pkg

// file: pkg/qpc_regs.svh
// constants for the quadrature position control block: offsets, fields, reset values
// assumes a 32-bit axi4-lite slave with word-aligned registers
// Function
// RULE1 - The counter enable bit at bit 15 lets the counters run when 1 and stops them when 0, while registers stay accessible.
// RULE2 - Unimplemented control bits, among them bits 14 and 7, read as zero and ignore writes.
// RULE3 - The stop-in-idle bit at bit 13 halts the block while the device is idle when 1, and lets it run when 0.
// RULE4 - The position init mode is a 3-bit field at bits 12 to 10, and code 111 is reserved.
// RULE5 - In mode 000 index events leave the position counter alone.
// RULE6 - In mode 001 every index event clears the position counter.
// RULE7 - In mode 010 the next index event loads the counter from the index init value register.
// RULE8 - In mode 011 the first index event after a home event loads the counter from the index init value register.
// RULE9 - In mode 100 the second index event after a home event loads the counter from the index init value register.
// RULE10 - In mode 101 the counter clears when it equals the greater-equal compare register.
// RULE11 - In mode 110 the counter counts modulo, wrapping between the compare bounds.
// RULE12 - The phase B match bit picks the phase B level needed for an index match.
// RULE13 - The phase A match bit at bit 8 picks the phase A level needed for an index match.
// RULE14 - An index event needs the index input active and both phases at their match levels on the same edge.
`ifndef QPC_REGS_SVH
`define QPC_REGS_SVH
`define QPC_OFS_CTRL       8'h00
`define QPC_OFS_POS        8'h04
`define QPC_OFS_INIT       8'h08
`define QPC_OFS_GEC        8'h0C
`define QPC_OFS_LEC        8'h10
`define QPC_OFS_STAT       8'h14
`define QPC_BIT_EN         15
`define QPC_BIT_SIDL       13
`define QPC_MODE_HI        12
`define QPC_MODE_LO        10
`define QPC_BIT_IMV_B      9
`define QPC_BIT_IMV_A      8
`define QPC_CTRL_MASK      32'h0000_BF00
`define QPC_CTRL_RST       32'h0000_0000
`define QPC_RESP_OKAY      2'b00
`define QPC_RESP_SLVERR    2'b10
`endif

// file: test/qpc_enc_model.sv
// incremental encoder model: gray-coded phases and a one-cycle index pulse
// assumes callers enter its tasks just after a rising clock edge, one at a time
module qpc_enc_model (
	input  wire logic i_clk,
	output logic      o_phase_a,
	output logic      o_phase_b,
	output logic      o_index
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] step_reg;
	// phases idle low like a real disc at rest
	initial begin
		step_reg = 2'h0;
		o_phase_a = 1'b0;
		o_phase_b = 1'b0;
		o_index = 1'b0;
	end
	// one quarter step; held 4 cycles so the 2-flop sync and counter settle
	task automatic step(input logic up);
		@(posedge i_clk);
		step_reg = up ? step_reg + 2'h1 : step_reg - 2'h1;
		// counting up walks {a, b} through 00-01-11-10
		o_phase_a <= step_reg[1];
		o_phase_b <= (step_reg == 2'h1) || (step_reg == 2'h2);
		repeat (4) @(posedge i_clk);
	endtask : step
	// shortest index mark the sync stage still sees
	task automatic pulse_index();
		@(posedge i_clk);
		o_index <= 1'b1;
		@(posedge i_clk);
		o_index <= 1'b0;
		repeat (4) @(posedge i_clk);
	endtask : pulse_index
endmodule : qpc_enc_model

// file: test/qpc_top_test.sv
// self-checking bench for qpc_top: axi4-lite register tasks plus encoder model
// assumes qpc_enc_model on the pins; bready and rready raised for each transfer only
`include "qpc_regs.svh"
module qpc_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import qpc_pkg::*;
	logic       i_clk = 1'b0, i_rst_n = 1'b0, i_home = 1'b0, i_idle = 1'b0;
	logic       s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic       s_axi_bready = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [3:0] s_axi_wstrb = 4'hF;
	qpc_word_t  s_axi_wdata = 32'h0000_0000, s_axi_rdata, o_position, rd;
	logic       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, o_index_event;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic       pa, pb, idx;
	int         n_mismatch = 0, n_checks = 0, cycles = 0, n_idx = 0;
	always #50 i_clk = ~i_clk;
	qpc_top qpc_top_inst (.i_clk, .i_rst_n, .i_phase_a_input(pa), .i_phase_b_input(pb), .i_index(idx),
		.i_home, .i_idle, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
		.o_position, .o_index_event);
	qpc_enc_model qpc_enc_model_inst (.i_clk, .o_phase_a(pa), .o_phase_b(pb), .o_index(idx));
	// handshakes judged at the rising edge; one idle edge after each transfer keeps ready toggles apart
	task automatic axi_write(input logic [7:0] a, input qpc_word_t d);
		logic b;
		b = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b) begin
			@(posedge i_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			b = s_axi_bvalid;
		end
		s_axi_bready <= 1'b0;
		@(posedge i_clk);
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a);
		logic r;
		r = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r) begin
			@(posedge i_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			r = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
		end
		s_axi_rready <= 1'b0;
		@(posedge i_clk);
	endtask : axi_read
	// index events are one-cycle pulses, so count them where they stand
	always @(posedge i_clk) begin
		if (o_index_event) n_idx <= n_idx + 1;
	end
	task automatic check(input qpc_word_t seen, input qpc_word_t exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic chk_reg(input logic [7:0] a, input qpc_word_t exp);
		axi_read(a);
		check(rd, exp);
	endtask : chk_reg
	// bus view and pin view of the counter must agree
	task automatic chk_pos(input qpc_word_t exp);
		chk_reg(`QPC_OFS_POS, exp);
		check(o_position, exp);
	endtask : chk_pos
	// enabled, given mode; match levels copy the live phases, flip bits spoil {b, a}
	task automatic setc(input logic [2:0] m, input logic [1:0] flip);
		axi_write(`QPC_OFS_CTRL, 32'h0000_8000 | (32'(m) << 10) | (32'({pb, pa} ^ flip) << 8));
	endtask : setc
	task automatic home();
		@(posedge i_clk);
		i_home <= 1'b1;
		@(posedge i_clk);
		i_home <= 1'b0;
		repeat (4) @(posedge i_clk);
	endtask : home
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	// a hang is cut short well past the few hundred cycles the run needs
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		chk_reg(`QPC_OFS_CTRL, 32'h0000_0000);
		repeat (4) qpc_enc_model_inst.step(1'b1);
		chk_pos(32'h0000_0000);
		axi_write(`QPC_OFS_CTRL, 32'hFFFF_FFFF);
		chk_reg(`QPC_OFS_CTRL, 32'h0000_BF00);
		// only byte 0 enabled: the implemented bits of byte 1 must survive
		s_axi_wstrb <= 4'h1;
		axi_write(`QPC_OFS_CTRL, 32'h0000_0000);
		s_axi_wstrb <= 4'hF;
		chk_reg(`QPC_OFS_CTRL, 32'h0000_BF00);
		axi_read(8'h3C);
		check(32'(rsp), 32'(`QPC_RESP_SLVERR));
		setc(3'h0, 2'b00);
		repeat (3) qpc_enc_model_inst.step(1'b1);
		qpc_enc_model_inst.step(1'b0);
		chk_pos(32'h0000_0002);
		// halted while idle, then idle with stop-in-idle clear keeps counting
		i_idle <= 1'b1;
		axi_write(`QPC_OFS_CTRL, 32'h0000_A000);
		qpc_enc_model_inst.step(1'b1);
		chk_pos(32'h0000_0002);
		qpc_enc_model_inst.step(1'b0);
		setc(3'h0, 2'b00);
		qpc_enc_model_inst.step(1'b1);
		chk_pos(32'h0000_0003);
		i_idle <= 1'b0;
		axi_write(`QPC_OFS_POS, 32'h0000_0010);
		axi_write(`QPC_OFS_INIT, 32'h0000_0055);
		setc(3'h1, 2'b01);
		qpc_enc_model_inst.pulse_index();
		chk_pos(32'h0000_0010);
		setc(3'h1, 2'b10);
		qpc_enc_model_inst.pulse_index();
		chk_pos(32'h0000_0010);
		setc(3'h1, 2'b00);
		qpc_enc_model_inst.pulse_index();
		chk_pos(32'h0000_0000);
		axi_write(`QPC_OFS_POS, 32'h0000_0010);
		setc(3'h0, 2'b00);
		qpc_enc_model_inst.pulse_index();
		chk_pos(32'h0000_0010);
		setc(3'h7, 2'b00);
		qpc_enc_model_inst.pulse_index();
		chk_pos(32'h0000_0010);
		setc(3'h2, 2'b00);
		qpc_enc_model_inst.pulse_index();
		chk_pos(32'h0000_0055);
		axi_write(`QPC_OFS_POS, 32'h0000_0010);
		qpc_enc_model_inst.pulse_index();
		chk_pos(32'h0000_0010);
		setc(3'h3, 2'b00);
		qpc_enc_model_inst.pulse_index();
		chk_pos(32'h0000_0010);
		home();
		qpc_enc_model_inst.pulse_index();
		chk_pos(32'h0000_0055);
		axi_write(`QPC_OFS_POS, 32'h0000_0010);
		setc(3'h4, 2'b00);
		home();
		qpc_enc_model_inst.pulse_index();
		chk_pos(32'h0000_0010);
		qpc_enc_model_inst.pulse_index();
		chk_pos(32'h0000_0055);
		axi_write(`QPC_OFS_GEC, 32'h0000_0012);
		axi_write(`QPC_OFS_POS, 32'h0000_0010);
		setc(3'h5, 2'b00);
		qpc_enc_model_inst.step(1'b1);
		chk_pos(32'h0000_0011);
		qpc_enc_model_inst.step(1'b1);
		chk_pos(32'h0000_0000);
		axi_write(`QPC_OFS_LEC, 32'h0000_0002);
		axi_write(`QPC_OFS_GEC, 32'h0000_0005);
		// leave compare-clear mode first, or a count equal to the bound is wiped at once
		setc(3'h6, 2'b00);
		axi_write(`QPC_OFS_POS, 32'h0000_0005);
		qpc_enc_model_inst.step(1'b1);
		chk_pos(32'h0000_0002);
		qpc_enc_model_inst.step(1'b0);
		chk_pos(32'h0000_0005);
		check(32'(n_idx), 32'h0000_0009);
		tally_and_finish();
	end
endmodule : qpc_top_test
